// ===== rtl/cpf_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Config registers writable only while port disabled
// - Slot field bits 7:3 gives value+1 slots
// - Mode bits 2:0 select protocol and lines
// - Ten mapped registers, four write-locked config
module cpf_top (
   input  wire logic                         aclk,           // System clock
   input  wire logic                         aresetn,        // Synchronous reset, low
   input  wire logic                         ce,             // Clock enable
   input  wire logic [cpf_pkg::ADDR_W-1:0]   awaddr,         // Write address
   input  wire logic [2:0]                   awprot,         // Unused protection
   input  wire logic                         awvalid,        // Write address valid
   output logic                              awready,        // Write address ready
   input  wire logic [cpf_pkg::DATA_W-1:0]   wdata,          // Write data
   input  wire logic [3:0]                   wstrb,          // Byte strobes
   input  wire logic                         wvalid,         // Write data valid
   output logic                              wready,         // Write data ready
   output logic [1:0]                        bresp,          // Write response
   output logic                              bvalid,         // Write response valid
   input  wire logic                         bready,         // Write response ready
   input  wire logic [cpf_pkg::ADDR_W-1:0]   araddr,         // Read address
   input  wire logic [2:0]                   arprot,         // Unused protection
   input  wire logic                         arvalid,        // Read address valid
   output logic                              arready,        // Read address ready
   output logic [cpf_pkg::DATA_W-1:0]        rdata,          // Read data
   output logic [1:0]                        rresp,          // Read response
   output logic                              rvalid,         // Read data valid
   input  wire logic                         rready,         // Read data ready
   input  wire logic                         link_clk,       // Serial link clock
   output logic                              lk_frame_sync,  // Pulse at slot 0
   output logic [4:0]                        lk_slot_idx,    // Current slot
   output logic [2:0]                        lk_proto,       // Captured protocol
   output logic [2:0]                        lk_out_lanes,   // Active output lines
   output logic [2:0]                        lk_in_lanes,    // Active input lines
   output logic                              lk_active       // Framing running
);
   import cpf_pkg::*;

   // Register storage and bus state
   logic [REG_W-1:0]   reg_r   [NREG];   // Stored registers
   logic [REG_W-1:0]   reg_nxt [NREG];   // Next values
   cpf_wstate_t        ws_r, ws_nxt;     // Write channel state
   cpf_rstate_t        rs_r, rs_nxt;     // Read channel state
   logic               aw_have_r, aw_have_nxt;  // Address held
   logic               w_have_r, w_have_nxt;    // Data held
   logic [ADDR_W-1:0]  aw_addr_r, aw_addr_nxt;  // Held address
   logic [REG_W-1:0]   w_data_r, w_data_nxt;    // Held low byte
   logic               w_lane_r, w_lane_nxt;    // Low lane strobe
   logic               awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0]         bresp_nxt, rresp_nxt;    // Response codes
   logic [DATA_W-1:0]  rdata_nxt;               // Read word
   logic [6:0]         frame_cnt_r, frame_cnt_nxt; // Frames seen
   logic               ftog_d_r;                // Last seen frame toggle
   logic               ftog_s, act_s;           // Synchronised frame toggle and link activity
   logic               wr_do;                   // Write performed this cycle
   logic               wr_hit, rd_hit, rd_stat; // Address mapped per channel, status read
   logic [3:0]         wr_idx, rd_idx;          // Target index per channel

   // Address decode into storage index
   function automatic logic [4:0] dec(input logic [ADDR_W-1:0] a);
      if (a == OFF_CFG1) begin
         dec = {1'b1, IDX_CFG1};
      end else if (a == OFF_CFG2) begin
         dec = {1'b1, 4'h1};
      end else if (a == OFF_CFG3) begin
         dec = {1'b1, 4'h2};
      end else if (a == OFF_CFG4) begin
         dec = {1'b1, IDX_CFG4};
      end else if (a == OFF_GCTL) begin
         dec = {1'b1, IDX_GCTL};
      end else if (a == OFF_AUX0) begin
         dec = {1'b1, IDX_AUX0};
      end else if (a == OFF_AUX1) begin
         dec = {1'b1, 4'h6};
      end else if (a == OFF_AUX2) begin
         dec = {1'b1, 4'h7};
      end else if (a == OFF_AUX3) begin
         dec = {1'b1, 4'h8};
      end else begin
         dec = 5'h00;
      end
   endfunction

   // Decode both channels
   always_comb begin
      {wr_hit, wr_idx} = dec(aw_addr_r);
      {rd_hit, rd_idx} = dec(araddr);
      rd_stat          = (araddr == OFF_STAT);
      wr_do            = (ws_r == WS_COLLECT) && aw_have_r && w_have_r;
   end

   // Write channel, register writes with lock
   always_comb begin
      ws_nxt      = ws_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_lane_nxt  = w_lane_r;
      bvalid_nxt  = bvalid;
      bresp_nxt   = bresp;
      for (int i = 0; i < NREG; i++) begin
         reg_nxt[i] = reg_r[i];
      end
      case (ws_r)
         WS_COLLECT: begin
            // Address and data accepted in either order
            if (awvalid && awready) begin
               aw_have_nxt = 1'b1;
               aw_addr_nxt = awaddr;
            end
            if (wvalid && wready) begin
               w_have_nxt = 1'b1;
               w_data_nxt = wdata[REG_W-1:0];
               w_lane_nxt = wstrb[0];
            end
            if (wr_do) begin
               aw_have_nxt = 1'b0;
               w_have_nxt  = 1'b0;
               bvalid_nxt  = 1'b1;
               bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
               ws_nxt      = WS_RESP;
               // Locked config ignored while the port runs
               if (wr_hit && w_lane_r &&
                   !(wr_idx <= IDX_CFG4 && reg_r[IDX_GCTL][EN_BIT])) begin
                  reg_nxt[wr_idx] = w_data_r;
               end
            end
         end
         WS_RESP: begin
            // Hold the answer until taken
            if (bready) begin
               bvalid_nxt = 1'b0;
               ws_nxt     = WS_COLLECT;
            end
         end
         default: ws_nxt = WS_COLLECT;  // Illegal code recovers
      endcase
      awready_nxt = (ws_nxt == WS_COLLECT) && !aw_have_nxt;
      wready_nxt  = (ws_nxt == WS_COLLECT) && !w_have_nxt;
   end

   // Read channel
   always_comb begin
      rs_nxt      = rs_r;
      rvalid_nxt  = rvalid;
      rresp_nxt   = rresp;
      rdata_nxt   = rdata;
      arready_nxt = arready;
      case (rs_r)
         RS_IDLE: begin
            if (arvalid && arready) begin
               rs_nxt      = RS_DATA;
               rvalid_nxt  = 1'b1;
               arready_nxt = 1'b0;
               rresp_nxt   = (rd_hit || rd_stat) ? RESP_OKAY : RESP_SLVERR;
               // Status shows frames counted and link activity
               if (rd_stat) begin
                  rdata_nxt = {24'h000000, frame_cnt_r, act_s};
               end else if (rd_hit) begin
                  rdata_nxt = {24'h000000, reg_r[rd_idx]};
               end else begin
                  rdata_nxt = 32'h00000000;
               end
            end else if (!arready) begin  // Offer the address slot once idle
               arready_nxt = 1'b1;
            end
         end
         RS_DATA: begin
            if (rready) begin
               rs_nxt      = RS_IDLE;
               rvalid_nxt  = 1'b0;
               arready_nxt = 1'b1;
            end
         end
         default: rs_nxt = RS_IDLE;  // Illegal code recovers
      endcase
   end

   // Frame counting from the link toggle
   always_comb begin
      frame_cnt_nxt = frame_cnt_r;
      if (ftog_s != ftog_d_r) begin
         frame_cnt_nxt = frame_cnt_r + 7'h01;
      end
   end

   // Bus-side registers, frozen while ce is low unless aresetn is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG; i++) begin
            reg_r[i] <= RST_REG;
         end
         ws_r        <= WS_COLLECT;
         rs_r        <= RS_IDLE;
         aw_have_r   <= 1'b0;
         w_have_r    <= 1'b0;
         aw_addr_r   <= 16'h0000;
         w_data_r    <= 8'h00;
         w_lane_r    <= 1'b0;
         awready     <= 1'b0;
         wready      <= 1'b0;
         bvalid      <= 1'b0;
         bresp       <= RESP_OKAY;
         arready     <= 1'b0;
         rvalid      <= 1'b0;
         rresp       <= RESP_OKAY;
         rdata       <= 32'h00000000;
         frame_cnt_r <= 7'h00;
         ftog_d_r    <= 1'b0;
      end else if (ce) begin
         reg_r       <= reg_nxt;
         ws_r        <= ws_nxt;
         rs_r        <= rs_nxt;
         aw_have_r   <= aw_have_nxt;
         w_have_r    <= w_have_nxt;
         aw_addr_r   <= aw_addr_nxt;
         w_data_r    <= w_data_nxt;
         w_lane_r    <= w_lane_nxt;
         awready     <= awready_nxt;
         wready      <= wready_nxt;
         bvalid      <= bvalid_nxt;
         bresp       <= bresp_nxt;
         arready     <= arready_nxt;
         rvalid      <= rvalid_nxt;
         rresp       <= rresp_nxt;
         rdata       <= rdata_nxt;
         frame_cnt_r <= frame_cnt_nxt;
         ftog_d_r    <= ftog_s;
      end
   end

   // Crossings between the domains
   logic lk_rstn;   // Reset as seen by the link
   logic lk_en;     // Port enable as seen by the link
   logic lk_ftog_r; // Frame toggle
   cpf_sync u_rst  (.clk(link_clk), .d(aresetn),                 .q(lk_rstn));
   cpf_sync u_en   (.clk(link_clk), .d(reg_r[IDX_GCTL][EN_BIT]), .q(lk_en));
   cpf_sync u_ftog (.clk(aclk),     .d(lk_ftog_r),               .q(ftog_s));
   cpf_sync u_act  (.clk(aclk),     .d(lk_active),               .q(act_s));

   // Link-side framing state
   logic [4:0] lk_slots_r, lk_slots_nxt;  // Last slot index of frame
   logic [4:0] lk_idx_nxt;                // Next slot
   logic [2:0] lk_proto_nxt;              // Next protocol
   logic [2:0] lk_out_nxt, lk_in_nxt;     // Next lane masks
   logic       lk_act_nxt, lk_fs_nxt, lk_ftog_nxt;

   // Slot sequencing and mode decode
   always_comb begin
      lk_slots_nxt = lk_slots_r;
      lk_idx_nxt   = lk_slot_idx;
      lk_proto_nxt = lk_proto;
      lk_out_nxt   = lk_out_lanes;
      lk_in_nxt    = lk_in_lanes;
      lk_act_nxt   = lk_active;
      lk_fs_nxt    = 1'b0;
      lk_ftog_nxt  = lk_ftog_r;
      if (!lk_en) begin
         lk_act_nxt = 1'b0;
         lk_idx_nxt = 5'h00;
      end else if (!lk_active) begin
         // Config is locked now, so a single capture is stable
         lk_slots_nxt = reg_r[IDX_CFG1][SLOT_MSB:SLOT_LSB];
         lk_proto_nxt = reg_r[IDX_CFG1][MODE_MSB:MODE_LSB];
         lk_act_nxt   = 1'b1;
         lk_idx_nxt   = 5'h00;
         lk_fs_nxt    = 1'b1;
         lk_ftog_nxt  = ~lk_ftog_r;
         case (reg_r[IDX_CFG1][MODE_MSB:MODE_LSB])
            MODE_I2S31: {lk_out_nxt, lk_in_nxt} = {LANES_3, LANES_1};
            MODE_I2S22: {lk_out_nxt, lk_in_nxt} = {LANES_2, LANES_2};
            MODE_I2S13: {lk_out_nxt, lk_in_nxt} = {LANES_1, LANES_3};
            default:    {lk_out_nxt, lk_in_nxt} = 6'h00;  // Non-I2S and reserved codes drive no lanes
         endcase
      end else if (lk_slot_idx == lk_slots_r) begin
         // Last slot wraps to a new frame
         lk_idx_nxt  = 5'h00;
         lk_fs_nxt   = 1'b1;
         lk_ftog_nxt = ~lk_ftog_r;
      end else begin
         lk_idx_nxt = lk_slot_idx + 5'h01;
      end
   end

   // Link registers
   always_ff @(posedge link_clk) begin
      if (!lk_rstn) begin
         lk_slots_r    <= 5'h00;
         lk_slot_idx   <= 5'h00;
         lk_proto      <= MODE_GP;
         lk_out_lanes  <= 3'h0;
         lk_in_lanes   <= 3'h0;
         lk_active     <= 1'b0;
         lk_frame_sync <= 1'b0;
         lk_ftog_r     <= 1'b0;
      end else begin
         lk_slots_r    <= lk_slots_nxt;
         lk_slot_idx   <= lk_idx_nxt;
         lk_proto      <= lk_proto_nxt;
         lk_out_lanes  <= lk_out_nxt;
         lk_in_lanes   <= lk_in_nxt;
         lk_active     <= lk_act_nxt;
         lk_frame_sync <= lk_fs_nxt;
         lk_ftog_r     <= lk_ftog_nxt;
      end
   end

   // Checks
   a_cfg_write_lock: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_do && wr_idx <= IDX_CFG4 && reg_r[IDX_GCTL][EN_BIT]
      |=> reg_r[IDX_CFG1] == $past(reg_r[IDX_CFG1]) && bvalid)
      else $error("locked config register changed");
   a_cfg_write_open: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_do && wr_hit && wr_idx == IDX_CFG1 && w_lane_r && !reg_r[IDX_GCTL][EN_BIT]
      |=> reg_r[IDX_CFG1] == $past(w_data_r))
      else $error("open config write not stored");
   a_slot_wrap: assert property (@(posedge link_clk) disable iff (!lk_rstn)
      lk_en && lk_active && lk_slot_idx == lk_slots_r
      |=> lk_slot_idx == 5'h00 && lk_frame_sync)
      else $error("frame did not wrap after last slot");
   a_lane_decode: assert property (@(posedge link_clk) disable iff (!lk_rstn)
      lk_active |-> (lk_proto == MODE_I2S31 ? (lk_out_lanes == LANES_3 && lk_in_lanes == LANES_1) :
                     lk_proto == MODE_I2S13 ? (lk_out_lanes == LANES_1 && lk_in_lanes == LANES_3) :
                     lk_proto == MODE_I2S22 ? (lk_out_lanes == LANES_2 && lk_in_lanes == LANES_2) :
                     (lk_out_lanes == 3'h0 && lk_in_lanes == 3'h0)))
      else $error("lane mask does not match protocol");
   a_mapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && arvalid && arready && (rd_hit || rd_stat)
      |=> rvalid && rresp == RESP_OKAY)
      else $error("mapped register read refused");
   a_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn && ce) |-> reg_r[IDX_CFG1] == RST_REG && reg_r[IDX_GCTL] == RST_REG)
      else $error("config not cleared by reset");
   c_cfg_write: cover property (@(posedge aclk) wr_do && wr_idx == IDX_CFG1);
   c_stat_read: cover property (@(posedge aclk) arvalid && arready && rd_stat);
   c_frame_wrap: cover property (@(posedge link_clk) lk_active && lk_frame_sync);
endmodule // cpf_top

// ===== rtl/cpf_pkg.sv
// Shared constants of the codec port frame configuration block
package cpf_pkg;

   // Bus geometry
   localparam int ADDR_W = 16;                        // Byte address width
   localparam int DATA_W = 32;                        // Bus data width
   localparam int REG_W  = 8;                         // Width of each register
   localparam int NREG   = 9;                         // Stored registers (status is extra)

   // Byte addresses of the ten registers
   localparam logic [ADDR_W-1:0] OFF_CFG1 = 16'hFFE0; // Frame and mode configuration
   localparam logic [ADDR_W-1:0] OFF_CFG2 = 16'hFFE4; // Configuration two
   localparam logic [ADDR_W-1:0] OFF_CFG3 = 16'hFFE8; // Configuration three
   localparam logic [ADDR_W-1:0] OFF_CFG4 = 16'hFFEC; // Configuration four
   localparam logic [ADDR_W-1:0] OFF_GCTL = 16'hFFF0; // Global control
   localparam logic [ADDR_W-1:0] OFF_STAT = 16'hFFF4; // Link status, read only
   localparam logic [ADDR_W-1:0] OFF_AUX0 = 16'hFFC8; // Operating register 0
   localparam logic [ADDR_W-1:0] OFF_AUX1 = 16'hFFCC; // Operating register 1
   localparam logic [ADDR_W-1:0] OFF_AUX2 = 16'hFFD0; // Operating register 2
   localparam logic [ADDR_W-1:0] OFF_AUX3 = 16'hFFD4; // Operating register 3

   // Storage indices
   localparam logic [3:0] IDX_CFG1 = 4'h0;            // First locked register
   localparam logic [3:0] IDX_CFG4 = 4'h3;            // Last locked register
   localparam logic [3:0] IDX_GCTL = 4'h4;            // Global control
   localparam logic [3:0] IDX_AUX0 = 4'h5;            // First operating register

   // Field positions
   localparam int SLOT_LSB = 3;                       // Slot count field low bit
   localparam int SLOT_MSB = 7;                       // Slot count field high bit
   localparam int MODE_LSB = 0;                       // Protocol selector low bit
   localparam int MODE_MSB = 2;                       // Protocol selector high bit
   localparam int EN_BIT   = 0;                       // Port enable bit in global control

   // Reset values
   localparam logic [REG_W-1:0] RST_REG = 8'h00;      // All stored registers

   // Protocol selector codes
   localparam logic [2:0] MODE_GP     = 3'h0;         // General purpose
   localparam logic [2:0] MODE_CODEC  = 3'h1;         // Codec-specific
   localparam logic [2:0] MODE_AC1    = 3'h2;         // AC '97 1.x
   localparam logic [2:0] MODE_AC2    = 3'h3;         // AC '97 2.x
   localparam logic [2:0] MODE_I2S31  = 3'h4;         // I2S, 3 out, 1 in
   localparam logic [2:0] MODE_I2S22  = 3'h5;         // I2S, 2 out, 2 in
   localparam logic [2:0] MODE_I2S13  = 3'h6;         // I2S, 1 out, 3 in
   localparam logic [2:0] MODE_RSVD   = 3'h7;         // Reserved

   // Lane masks per I2S mode
   localparam logic [2:0] LANES_1 = 3'h1;             // One data line
   localparam logic [2:0] LANES_2 = 3'h3;             // Two data lines
   localparam logic [2:0] LANES_3 = 3'h7;             // Three data lines

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;         // Normal answer
   localparam logic [1:0] RESP_SLVERR = 2'h2;         // Unmapped address, or a write to the read-only status

   // Write channel states
   typedef enum logic [1:0] {
      WS_COLLECT = 2'b01,                             // Gathering address and data
      WS_RESP    = 2'b10                              // Response offered
   } cpf_wstate_t;

   // Read channel states
   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,                                // Waiting for an address
      RS_DATA = 2'b10                                 // Data offered
   } cpf_rstate_t;

endpackage

// ===== rtl/cpf_sync.sv
`timescale 1ns/1ps
// Three-stage level synchroniser; output moves once stages two and three agree
module cpf_sync (
   input  wire logic clk,    // Destination clock
   input  wire logic d,      // Level from the other domain
   output logic      q       // Filtered level
);
   import cpf_pkg::*;

   logic s1_r;               // First stage, read only by s2
   logic s2_r;               // Second stage
   logic s3_r;               // Third stage
   logic q_nxt;              // Next output

   // Output follows once the last two stages agree
   always_comb begin
      q_nxt = q;
      if (s2_r == s3_r) begin
         q_nxt = s3_r;
      end
   end

   // Shift chain
   always_ff @(posedge clk) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
   end
endmodule // cpf_sync

// ===== dv/cpf_codec_model.sv
`timescale 1ns/1ps
// Codec at the far end of the link: makes the link clock, measures frames
module cpf_codec_model (
   output logic      link_clk,       // Link clock from the codec
   input  wire logic lk_frame_sync,  // Frame start pulse from the port
   input  wire logic [4:0] lk_slot_idx, // Slot index from the port
   output int        n_frames,       // Frame starts seen
   output int        frame_len,      // Link cycles in the last whole frame
   output int        n_idx_bad       // Slot indices out of step
);
   int cnt;                          // Link cycles since the last frame start

   // Runs free so the port can see its enable and reset, phase unrelated to aclk
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #62.5 link_clk = ~link_clk;
   end

   // Count slots between frame starts
   always @(posedge link_clk) begin
      // Mid-frame index must equal link cycles since the frame start
      if (lk_slot_idx != 5'h00 && (lk_frame_sync || int'(lk_slot_idx) != cnt)) begin
         n_idx_bad <= n_idx_bad + 1;
      end
      if (lk_frame_sync) begin
         frame_len <= cnt;
         n_frames <= n_frames + 1;
         cnt <= 1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // cpf_codec_model

// ===== dv/cpf_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module cpf_top_tb;
   import cpf_pkg::*;
   logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready; // Bench-driven controls
   logic [ADDR_W-1:0] awaddr, araddr;                                        // Addresses
   logic [DATA_W-1:0] wdata;                                                 // Write data
   wire logic         awready, wready, bvalid, arready, rvalid;              // Bus answers
   wire logic         link_clk, lk_frame_sync, lk_active;                    // Link signals
   wire logic [1:0]   bresp, rresp;                                          // Responses
   wire logic [31:0]  rdata;                                                 // Read data
   wire logic [4:0]   lk_slot_idx;                                           // Slot index
   wire logic [2:0]   lk_proto, lk_out_lanes, lk_in_lanes;                   // Mode outputs
   int                n_errors, compares, n_frames, frame_len, n_idx_bad;    // Counters
   logic [3:0]        wstrb;                                                 // Byte strobes
   int                seed = 32'hcefd6345;                                   // Fixed seed
   logic [15:0]       offs [10] = '{OFF_CFG1, OFF_CFG2, OFF_CFG3, OFF_CFG4, OFF_GCTL,
                                    OFF_STAT, OFF_AUX0, OFF_AUX1, OFF_AUX2, OFF_AUX3};

   cpf_top uut (.aclk, .aresetn, .ce(1'h1), .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .lk_frame_sync, .lk_slot_idx,
      .lk_proto, .lk_out_lanes, .lk_in_lanes, .lk_active);
   cpf_codec_model codec (.link_clk, .lk_frame_sync, .lk_slot_idx, .n_frames, .frame_len, .n_idx_bad);

   // System clock, 20 ns
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Expected output and input line masks
   function automatic logic [5:0] lanes(input logic [2:0] m);
      case (m)
         MODE_I2S31: return {LANES_3, LANES_1};
         MODE_I2S22: return {LANES_2, LANES_2};
         MODE_I2S13: return {LANES_1, LANES_3};
         default: return 6'h00;
      endcase
   endfunction

   // Write with both channels offered together, wait for the response
   task automatic wr_chk(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      `CHK("bresp", er, bresp)
   endtask

   // Read and compare data and response
   task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      `CHK(nm, ed, rdata)
      `CHK("rresp", er, rresp)
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("Mismatches %0d, comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, well beyond eight mode passes
   initial begin
      repeat (40000) @(posedge aclk);
      n_errors++;
      finish_test();
   end

   // Main sequence
   initial begin
      logic [7:0] cfg;
      logic [2:0] m;
      int         f0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      // Reset for 20 cycles, then let the link side settle
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (20) @(posedge aclk);
      foreach (offs[i]) rd_chk("reset", offs[i], 32'h0, RESP_OKAY);
      rd_chk("unmapped", 16'h0000, 32'h0, RESP_SLVERR);
      wr_chk(OFF_STAT, 8'h5A, RESP_SLVERR);
      cfg = 8'($random(seed));
      wr_chk(OFF_AUX2, cfg, RESP_OKAY);
      rd_chk("aux", OFF_AUX2, {24'h0, cfg}, RESP_OKAY);
      // Low lane strobe off: answered but not stored
      wstrb <= 4'h0;
      wr_chk(OFF_AUX2, ~cfg, RESP_OKAY);
      wstrb <= 4'hF;
      rd_chk("no strobe", OFF_AUX2, {24'h0, cfg}, RESP_OKAY);
      // Every mode code, slot count at both ends and random between
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         cfg = {(m == 3'h0) ? 5'h00 : (m == 3'h7) ? 5'h1F : 5'($random(seed)), m};
         wr_chk(OFF_CFG1, cfg, RESP_OKAY);
         rd_chk("cfg1", OFF_CFG1, {24'h0, cfg}, RESP_OKAY);
         wr_chk(OFF_GCTL, 8'h01, RESP_OKAY);
         wr_chk(OFF_CFG1, ~cfg, RESP_OKAY);
         rd_chk("locked", OFF_CFG1, {24'h0, cfg}, RESP_OKAY);
         f0 = n_frames;
         while (n_frames < f0 + 3) @(posedge aclk);
         `CHK("proto", m, lk_proto)
         `CHK("lanes", lanes(m), {lk_out_lanes, lk_in_lanes})
         `CHK("slots", int'(cfg[7:3]) + 1, frame_len)
         wr_chk(OFF_GCTL, 8'h00, RESP_OKAY);
         while (lk_active) @(posedge aclk);
         // Let the frame toggle and activity cross back
         repeat (8) @(posedge aclk);
         rd_chk("status", OFF_STAT, {24'h0, n_frames[6:0], 1'b0}, RESP_OKAY);
      end
      `CHK("slot index", 0, n_idx_bad)
      finish_test();
   end
endmodule // cpf_top_tb
